// ==== common/asf_pkg.sv ====
// Purpose: shared constants and carriers of the sample queue and interrupt block
// Assumes: byte-wide register port, one sample clock
// Notes:   offsets are byte addresses of the register port
package asf_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ASF_OFS_X_LSB     = 8'h02;
  localparam logic [7:0] ASF_OFS_Z_MSB     = 8'h07;
  localparam logic [7:0] ASF_OFS_RANGE_CTL = 8'h15;
  localparam logic [7:0] ASF_OFS_QUEUE_CTL = 8'h16;
  localparam logic [7:0] ASF_OFS_IRQ_CTL   = 8'h17;

  localparam logic [7:0] ASF_RST_RANGE_CTL = 8'h00;
  localparam logic [7:0] ASF_RST_QUEUE_CTL = 8'h00;
  localparam logic [7:0] ASF_RST_IRQ_CTL   = 8'h00;
  // reserved bits 7 and 3 of range_resolution_control read as zero
  localparam logic [7:0] ASF_MASK_RANGE    = 8'h77;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ASF_BIT_WIDTH_LO   = 0;
  localparam int ASF_BIT_RANGE_LO   = 4;
  localparam int ASF_BIT_THRESH_LO  = 0;
  localparam int ASF_BIT_FILL_MODE  = 5;
  localparam int ASF_BIT_QUEUE_EN   = 6;
  localparam int ASF_BIT_QUEUE_RST  = 7;
  localparam int ASF_BIT_DRIVE      = 0;
  localparam int ASF_BIT_POLARITY   = 1;
  localparam int ASF_BIT_EN_WAKE    = 2;
  localparam int ASF_BIT_EN_NEW     = 3;
  localparam int ASF_BIT_EN_EMPTY   = 4;
  localparam int ASF_BIT_EN_FULL    = 5;
  localparam int ASF_BIT_EN_LEVEL   = 6;
  localparam int ASF_BIT_EN_WATCHED = 7;

  // ****************************************
  // widths and depths
  // ****************************************
  localparam int          ASF_RAW_W     = 14;
  localparam int          ASF_WORD_W    = 12;
  localparam int          ASF_DEPTH     = 32;
  localparam int          ASF_PTR_W     = 5;
  localparam int          ASF_CNT_W     = 6;
  localparam logic [5:0]  ASF_CNT_FULL  = 6'h20;
  localparam logic [3:0]  ASF_BITS_QMAX = 4'hc;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asf_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  axis;
    logic [13:0] raw;
  } asf_sample_t;

  typedef struct packed {
    logic q_empty;
    logic q_full;
    logic q_level;
  } asf_queue_flags_t;

endpackage

// ==== design/asf_sample_format.sv ====
// Purpose: cut a raw sample to the selected width and decode the range code
// Assumes: raw samples arrive at full 14-bit two's complement resolution
// Notes:   purely combinational; reserved width codes fall back to 12 bits
`timescale 1ns/1ps
module asf_sample_format
  import asf_pkg::*;
(
  input  wire logic [ASF_RAW_W-1:0] raw,
  input  wire logic [2:0]           width_code,
  input  wire logic [2:0]           range_code,
  input  wire logic                 queue_en,
  output logic      [15:0]          sample_ext,
  output logic      [3:0]           sample_bits,
  output logic      [4:0]           full_scale_g
);

  function automatic logic [3:0] width_of(input logic [2:0] code, input logic qen);
    logic [3:0] w;
    w = 4'hc;
    unique case (code)
      3'h0:    w = 4'h6;
      3'h1:    w = 4'h7;
      3'h2:    w = 4'h8;
      3'h3:    w = 4'ha;
      3'h4:    w = 4'hc;
      3'h5:    w = 4'he;
      default: w = 4'hc;
    endcase
    // the queue word is only 12 bits wide
    if (qen && (w > ASF_BITS_QMAX))
    begin
      w = ASF_BITS_QMAX;
    end
    return w;
  endfunction

  function automatic logic [4:0] range_of(input logic [2:0] code);
    logic [4:0] g;
    g = 5'h00;
    unique case (code)
      3'h0:    g = 5'h02;
      3'h1:    g = 5'h04;
      3'h2:    g = 5'h08;
      3'h3:    g = 5'h10;
      3'h4:    g = 5'h0c;
      default: g = 5'h00;
    endcase
    return g;
  endfunction

  logic signed [15:0] wide;
  logic        [3:0]  shift;

  always_comb
  begin
    sample_bits  = width_of(width_code, queue_en);
    full_scale_g = range_of(range_code);
    wide         = $signed({{2{raw[ASF_RAW_W-1]}}, raw});
    shift        = 4'he - sample_bits;
    sample_ext   = wide >>> shift;  // sign-extended result
  end

endmodule

// ==== design/asf_sample_irq_ctrl.sv ====
// Purpose: output formatting, sample queue and interrupt request of a motion sensor
// Assumes: register port and event inputs come from logic on ref_clk
// Notes:   read data appears one cycle after the read strobe
`timescale 1ns/1ps

// Notes on behaviour
// - results appear sign-extended two's complement in the data registers 0x02 to 0x07.
// - with the queue enabled, the 14-bit setting gives 12-bit results.
// - width code 0..5 means 6,7,8,10,12,14 bits; 6 and 7 reserved.
// - queue events, threshold and fill mode act only while the queue is enabled.
// - with the queue disabled its flags show their default values.
// - five-bit threshold holds the event count; host programs 1 to 31.
// - fill mode 0 accepts samples while space remains.
// - fill mode 1 drops samples once the count reaches the threshold.
// - queue disabled writes each x, y or z sample straight into the data registers; axis code 3 is not stored.
// - queue enabled writes each sample into the queue when it has room.
// - queue writing runs only while the queue is enabled.
// - queue reset bit asynchronously clears pointers and contents.
// - drive bit 0 selects open-drain, 1 push-pull for the pin.
// - polarity bit 0 gives active low request, 1 active high.
// - enable bit 2 requests on activity wake into the continuous active state.
// - enable bit 3 requests on every new sample stored.
// - enable bit 4 requests when the queue count is 0.
// - enable bit 5 requests when the queue count is 32.
// - enable bit 6 requests when the count reaches the threshold.
// - enable bit 7 requests on activity only in the watched active state.
// - watched activity holds the detector until its manual reset is applied and removed.
module asf_sample_irq_ctrl
  import asf_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire asf_reg_req_t     reg_req,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  input  wire asf_sample_t      sample_in,
  input  wire logic             wake_event,
  input  wire logic             watched_activity,
  input  wire logic             watched_active_state,
  input  wire logic             activity_unit_reset,
  input  wire logic             irq_ack,
  output asf_queue_flags_t      queue_flags,
  output logic      [4:0]       full_scale_g,
  output logic      [3:0]       sample_bit_width,
  output logic                  activity_unit_hold,
  output logic                  irq_out_pin_o,
  output logic                  irq_out_pin_oe
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0]      range_ctl;
    logic [7:0]      queue_ctl;
    logic [7:0]      irq_ctl;
    logic [5:0][7:0] out_data;
    logic            pend_new;
    logic            pend_wake;
    logic            pend_watched;
    logic            act_lock;
    logic            act_rst_seen;
    logic [7:0]      rdata;
    logic            rvalid;
    logic            pin_o;
    logic            pin_oe;
  } asf_ctrl_state_t;

  asf_ctrl_state_t q;
  asf_ctrl_state_t next_q;

  // ****************************************
  // field views
  // ****************************************
  logic       queue_en;
  logic       fill_mode;
  logic       queue_rst;
  logic [4:0] queue_level_threshold;
  logic       irq_drive_style;
  logic       irq_polarity;
  logic       irq_on_new_sample;
  logic       irq_on_queue_level;
  logic       irq_on_watched_activity;

  assign queue_en                = q.queue_ctl[ASF_BIT_QUEUE_EN];
  assign fill_mode               = q.queue_ctl[ASF_BIT_FILL_MODE];
  assign queue_rst               = q.queue_ctl[ASF_BIT_QUEUE_RST];
  assign queue_level_threshold   = q.queue_ctl[ASF_BIT_THRESH_LO +: 5];
  assign irq_drive_style         = q.irq_ctl[ASF_BIT_DRIVE];
  assign irq_polarity            = q.irq_ctl[ASF_BIT_POLARITY];
  assign irq_on_new_sample       = q.irq_ctl[ASF_BIT_EN_NEW];
  assign irq_on_queue_level      = q.irq_ctl[ASF_BIT_EN_LEVEL];
  assign irq_on_watched_activity = q.irq_ctl[ASF_BIT_EN_WATCHED];

  // ****************************************
  // formatter and queue
  // ****************************************
  logic [15:0]           sample_ext;
  logic [ASF_WORD_W-1:0] head_data;
  logic [ASF_CNT_W-1:0]  q_count;
  logic                  q_push;
  logic                  q_pop;
  logic                  q_room;
  logic                  q_clr;
  logic                  at_level;
  logic [15:0]           head_ext;

  asf_sample_format u_format (
    .raw          (sample_in.raw),
    .width_code   (q.range_ctl[ASF_BIT_WIDTH_LO +: 3]),
    .range_code   (q.range_ctl[ASF_BIT_RANGE_LO +: 3]),
    .queue_en     (queue_en),
    .sample_ext   (sample_ext),
    .sample_bits  (sample_bit_width),
    .full_scale_g (full_scale_g)
  );

  // the clear comes straight from a flop, so it cannot glitch; it acts whatever
  // the enable says
  assign q_clr = rst | queue_rst;

  asf_sample_queue u_queue (
    .ref_clk   (ref_clk),
    .clr       (q_clr),
    .push      (q_push),
    .push_data (sample_ext[ASF_WORD_W-1:0]),
    .pop       (q_pop),
    .head_data (head_data),
    .count     (q_count)
  );

  assign at_level = ({1'b0, queue_level_threshold} <= q_count);
  // watermark stops at the threshold, normal mode only at full
  assign q_room   = (q_count != ASF_CNT_FULL) && !(fill_mode && at_level);
  // the write strobe is gated by the enable in place of a gated clock
  assign q_push   = sample_in.valid && queue_en && q_room;
  // reading the high byte of the x slot takes the head word off the queue
  assign q_pop    = reg_req.rd && queue_en && (reg_req.addr == ASF_OFS_X_LSB + 8'h01);
  assign head_ext = {{4{head_data[ASF_WORD_W-1]}}, head_data};

  // ****************************************
  // queue flags
  // ****************************************
  logic flag_empty;
  logic flag_full;
  logic flag_level;

  // a disabled queue reports empty, not full, below level
  assign flag_empty = !queue_en || (q_count == '0);
  assign flag_full  = queue_en && (q_count == ASF_CNT_FULL);
  assign flag_level = queue_en && at_level;

  // ****************************************
  // next state
  // ****************************************
  logic       stored;
  logic       watched_hit;
  logic       req;
  logic       level_hi;
  logic [7:0] offs;

  always_comb
  begin
    next_q      = q;
    offs        = reg_req.addr - ASF_OFS_X_LSB;
    stored      = sample_in.valid && (!queue_en || q_push);
    watched_hit = watched_activity && watched_active_state && !q.act_lock;

    // register writes
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        ASF_OFS_RANGE_CTL: next_q.range_ctl = reg_req.wdata & ASF_MASK_RANGE;
        ASF_OFS_QUEUE_CTL: next_q.queue_ctl = reg_req.wdata;
        ASF_OFS_IRQ_CTL:   next_q.irq_ctl   = reg_req.wdata;
        default:           next_q.range_ctl = q.range_ctl;
      endcase
    end

    // direct path to the data registers, low byte first
    if (sample_in.valid && !queue_en && (sample_in.axis != 2'h3))
    begin
      next_q.out_data[{sample_in.axis, 1'b0}] = sample_ext[7:0];
      next_q.out_data[{sample_in.axis, 1'b1}] = sample_ext[15:8];
    end

    // register reads
    next_q.rvalid = reg_req.rd;
    next_q.rdata  = 8'h00;
    if (reg_req.rd)
    begin
      if ((reg_req.addr >= ASF_OFS_X_LSB) && (reg_req.addr <= ASF_OFS_Z_MSB))
      begin
        if (queue_en && (offs[2:0] == 3'h0))
        begin
          next_q.rdata = head_ext[7:0];
        end
        else if (queue_en && (offs[2:0] == 3'h1))
        begin
          next_q.rdata = head_ext[15:8];
        end
        else
        begin
          next_q.rdata = q.out_data[offs[2:0]];
        end
      end
      else if (reg_req.addr == ASF_OFS_RANGE_CTL)
      begin
        next_q.rdata = q.range_ctl;
      end
      else if (reg_req.addr == ASF_OFS_QUEUE_CTL)
      begin
        next_q.rdata = q.queue_ctl;
      end
      else if (reg_req.addr == ASF_OFS_IRQ_CTL)
      begin
        next_q.rdata = q.irq_ctl;
      end
    end

    // sticky event requests; a new event beats an ack in the same cycle
    if (irq_ack)
    begin
      next_q.pend_new     = 1'b0;
      next_q.pend_wake    = 1'b0;
      next_q.pend_watched = 1'b0;
    end
    if (stored && irq_on_new_sample)
    begin
      next_q.pend_new = 1'b1;
    end
    if (wake_event && q.irq_ctl[ASF_BIT_EN_WAKE])
    begin
      next_q.pend_wake = 1'b1;
    end
    if (watched_hit && irq_on_watched_activity)
    begin
      next_q.pend_watched = 1'b1;
    end

    // detector stays held until its reset goes high and then low again
    if (activity_unit_reset)
    begin
      next_q.act_rst_seen = 1'b1;
    end
    else if (q.act_rst_seen)
    begin
      next_q.act_rst_seen = 1'b0;
      next_q.act_lock     = 1'b0;
    end
    // a hit in the release cycle must not be lost, so the set comes last
    if (watched_hit)
    begin
      next_q.act_lock = 1'b1;
    end

    // OR of everything enabled, then polarity and drive
    req = q.pend_new || q.pend_wake || q.pend_watched
          || (q.irq_ctl[ASF_BIT_EN_EMPTY] && queue_en && (q_count == '0))
          || (q.irq_ctl[ASF_BIT_EN_FULL] && flag_full)
          || (irq_on_queue_level && flag_level);
    level_hi = irq_polarity ? req : !req;
    if (irq_drive_style)
    begin
      next_q.pin_o  = level_hi;
      next_q.pin_oe = 1'b1;
    end
    else
    begin
      // open drain only ever pulls low; the pull-up gives the high level
      next_q.pin_o  = 1'b0;
      next_q.pin_oe = !level_hi;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      q           <= '0;
      q.range_ctl <= ASF_RST_RANGE_CTL;
      q.queue_ctl <= ASF_RST_QUEUE_CTL;
      q.irq_ctl   <= ASF_RST_IRQ_CTL;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign reg_rdata          = q.rdata;
  assign reg_rvalid         = q.rvalid;
  assign queue_flags        = '{q_empty: flag_empty, q_full: flag_full, q_level: flag_level};
  assign activity_unit_hold = q.act_lock;
  assign irq_out_pin_o      = q.pin_o;
  assign irq_out_pin_oe     = q.pin_oe;

endmodule

// ==== design/asf_sample_queue.sv ====
// Purpose: 32-entry first-in first-out store of 12-bit sample words
// Assumes: clr is the async clear (power-on reset or software queue reset)
// Notes:   a push into a full queue and a pop from an empty one are ignored
`timescale 1ns/1ps
module asf_sample_queue
  import asf_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  clr,
  input  wire logic                  push,
  input  wire logic [ASF_WORD_W-1:0] push_data,
  input  wire logic                  pop,
  output logic      [ASF_WORD_W-1:0] head_data,
  output logic      [ASF_CNT_W-1:0]  count
);

  typedef struct packed {
    logic [ASF_DEPTH-1:0][ASF_WORD_W-1:0] mem;
    logic [ASF_PTR_W-1:0]                 wp;
    logic [ASF_PTR_W-1:0]                 rp;
    logic [ASF_CNT_W-1:0]                 cnt;
  } asf_queue_state_t;

  asf_queue_state_t q;
  asf_queue_state_t next_q;
  logic             do_push;
  logic             do_pop;

  always_comb
  begin
    next_q  = q;
    do_push = push && (q.cnt != ASF_CNT_FULL);
    do_pop  = pop && (q.cnt != '0);
    if (do_push)
    begin
      next_q.mem[q.wp] = push_data;
      next_q.wp        = q.wp + 5'h01;
    end
    if (do_pop)
    begin
      next_q.rp = q.rp + 5'h01;
    end
    if (do_push && !do_pop)
    begin
      next_q.cnt = q.cnt + 6'h01;
    end
    else if (do_pop && !do_push)
    begin
      next_q.cnt = q.cnt - 6'h01;
    end
  end

  // clearing the contents too means no stale word can be read back straight after a clear
  always_ff @(posedge ref_clk or posedge clr)
  begin
    if (clr)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign head_data = q.mem[q.rp];
  assign count     = q.cnt;

endmodule

// ==== verification/asf_host_model.sv ====
// Purpose: host side of the register port
// Assumes: strobes launched just after a rising edge, one cycle long
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
module asf_host_model
  import asf_pkg::*;
(
  input  wire logic       ref_clk,
  output asf_reg_req_t    reg_req,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // answer is taken just after the edge that launches it
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b1, a, ~reg_req.wdata};
    @(posedge ref_clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~reg_req.wdata};
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule

// ==== verification/asf_sample_irq_ctrl_asserts.sv ====
// Purpose: port-level checks of the sample queue and interrupt block
// Assumes: one clock, async active-high reset
// Notes:   sees the top-level ports only
`timescale 1ns/1ps
module asf_sample_irq_ctrl_asserts
  import asf_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             rst,
  input wire asf_reg_req_t     reg_req,
  input wire logic [7:0]       reg_rdata,
  input wire logic             reg_rvalid,
  input wire logic             watched_activity,
  input wire logic             watched_active_state,
  input wire logic             activity_unit_reset,
  input wire asf_queue_flags_t queue_flags,
  input wire logic [4:0]       full_scale_g,
  input wire logic [3:0]       sample_bit_width,
  input wire logic             activity_unit_hold,
  input wire logic             irq_out_pin_o,
  input wire logic             irq_out_pin_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // properties
  // ****************************************
  sequence s_rd_unmapped;
    reg_req.rd && !(reg_req.addr inside {[8'h02:8'h07], [8'h15:8'h17]});
  endsequence
  sequence s_zero_answer;
    reg_rvalid && reg_rdata == 8'h00;
  endsequence
  property p_rd_answer; reg_req.rd |=> reg_rvalid; endproperty
  property p_rd_idle; !reg_req.rd |=> !reg_rvalid && reg_rdata == 8'h00; endproperty
  property p_unmapped; s_rd_unmapped |=> s_zero_answer; endproperty
  property p_width; sample_bit_width inside {4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'he}; endproperty
  property p_scale; full_scale_g inside {5'h0, 5'h2, 5'h4, 5'h8, 5'hc, 5'h10}; endproperty
  property p_full; queue_flags.q_full |-> queue_flags.q_level && !queue_flags.q_empty;
  endproperty
  property p_od_low; !irq_out_pin_oe |-> !irq_out_pin_o; endproperty
  property p_hold_cause;
    $rose(activity_unit_hold) |-> $past(watched_activity && watched_active_state);
  endproperty
  // the hold may only end after a manual reset pulse of the detector
  property p_hold_keep;
    activity_unit_hold && !activity_unit_reset && !$past(activity_unit_reset)
      && !$past(activity_unit_reset, 2) |=> activity_unit_hold;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  a_rd_idle: assert property (p_rd_idle) else $error("stray read answer");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_width: assert property (p_width) else $error("illegal sample width");
  a_scale: assert property (p_scale) else $error("illegal full scale");
  a_full: assert property (p_full) else $error("full flag inconsistent");
  a_od_low: assert property (p_od_low) else $error("released pin not low");
  a_hold_cause: assert property (p_hold_cause) else $error("hold without cause");
  a_hold_keep: assert property (p_hold_keep) else $error("hold dropped early");
endmodule

bind asf_sample_irq_ctrl asf_sample_irq_ctrl_asserts u_asserts (
  .ref_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .watched_activity,
  .watched_active_state, .activity_unit_reset, .queue_flags, .full_scale_g,
  .sample_bit_width, .activity_unit_hold, .irq_out_pin_o, .irq_out_pin_oe);

// ==== verification/asf_sample_irq_ctrl_tb_top.sv ====
// Purpose: register-level tests of the sample queue and interrupt block
// Assumes: host model drives the register port
// Notes:   expected values are worked out from the field encodings
`timescale 1ns/1ps
module asf_sample_irq_ctrl_tb_top
  import asf_pkg::*;
;
  logic             ref_clk, rst, reg_rvalid, rv;
  logic             watched_active_state, activity_unit_reset, activity_unit_hold;
  logic             irq_out_pin_o, irq_out_pin_oe;
  logic [2:0]       ev;
  logic [7:0]       reg_rdata, rdat;
  logic [4:0]       full_scale_g;
  logic [3:0]       sample_bit_width;
  asf_reg_req_t     reg_req;
  asf_sample_t      sample_in;
  asf_queue_flags_t queue_flags;
  int               mismatches, cmp_count;
  byte              bits_tab[8] = '{6, 7, 8, 10, 12, 14, 12, 12};
  byte              g_tab[8] = '{2, 4, 8, 16, 12, 0, 0, 0};
  logic [7:0]       wc[3] = '{8'h05, 8'h00, 8'h04};
  logic [13:0]      rw[3] = '{14'h2001, 14'h2001, 14'h1fff};
  logic [15:0]      ex[3] = '{16'he001, 16'hffe0, 16'h07ff};

  asf_sample_irq_ctrl u_dut (
    .ref_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid, .sample_in,
    .wake_event(ev[0]), .watched_activity(ev[1]), .watched_active_state,
    .activity_unit_reset, .irq_ack(ev[2]), .queue_flags, .full_scale_g,
    .sample_bit_width, .activity_unit_hold, .irq_out_pin_o, .irq_out_pin_oe);
  asf_host_model u_host (.ref_clk, .reg_req, .reg_rdata, .reg_rvalid);

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    u_host.rd(a, rdat, rv);
    chk("rvalid", {15'h0, rv}, 16'h1);
    chk(nm, {8'h0, rdat}, {8'h0, e});
  endtask
  task automatic smp(input logic [1:0] ax, input logic [13:0] r);
    @(posedge ref_clk);
    sample_in <= '{1'b1, ax, r};
    @(posedge ref_clk);
    sample_in.valid <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 3'h0;
  endtask
  // request and pin are each registered once, so two edges settle them
  task automatic pin(input logic o, input logic oe, input string nm);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(nm, {14'h0, irq_out_pin_o, irq_out_pin_oe}, {14'h0, o, oe});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #500000;
    mismatches++;
    stop_test();
  end
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    rst = 1'b1;
    sample_in = '0;
    ev = 3'h0;
    watched_active_state = 1'b0;
    activity_unit_reset = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    pin(1'b0, 1'b0, "pin idle");
    for (int i = 0; i < 4; i++)
      rc(8'(8'h15 + i), 8'h00, "reset value");
    for (int i = 0; i < 8; i++)
    begin
      u_host.wr(ASF_OFS_RANGE_CTL, {1'b1, 3'(i), 1'b1, 3'(i)});
      #1;
      chk("bits", 16'(sample_bit_width), 16'(bits_tab[i]));
      chk("scale", 16'(full_scale_g), 16'(g_tab[i]));
    end
    rc(ASF_OFS_RANGE_CTL, 8'h77, "range mask");
    chk("flags off", 16'(queue_flags), 16'h4);
    for (int i = 0; i < 3; i++)
    begin
      u_host.wr(ASF_OFS_RANGE_CTL, wc[i]);
      smp(2'(i), rw[i]);
      rc(8'(ASF_OFS_X_LSB + 2 * i), ex[i][7:0], "data lsb");
      rc(8'(ASF_OFS_X_LSB + 2 * i + 1), ex[i][15:8], "data msb");
    end
    // watermark mode with threshold 4: later samples are dropped
    u_host.wr(ASF_OFS_QUEUE_CTL, 8'h64);
    u_host.wr(ASF_OFS_RANGE_CTL, 8'h05);
    #1;
    chk("capped bits", 16'(sample_bit_width), 16'hc);
    for (int i = 1; i < 7; i++)
      smp(2'h0, 14'(i * 20));
    chk("flags mark", 16'(queue_flags), 16'h1);
    for (int i = 1; i < 5; i++)
    begin
      rc(ASF_OFS_X_LSB, 8'(i * 5), "queue lsb");
      rc(8'h03, 8'h00, "queue msb");
    end
    chk("flags drained", 16'(queue_flags), 16'h4);
    u_host.wr(ASF_OFS_QUEUE_CTL, 8'h44);
    repeat (33) smp(2'h0, 14'h0);
    chk("flags full", 16'(queue_flags), 16'h3);
    u_host.wr(ASF_OFS_IRQ_CTL, 8'h23);
    pin(1'b1, 1'b1, "full irq");
    u_host.wr(ASF_OFS_QUEUE_CTL, 8'hc4);
    #1;
    chk("flags reset", 16'(queue_flags), 16'h4);
    pin(1'b0, 1'b1, "full gone");
    u_host.wr(ASF_OFS_QUEUE_CTL, 8'h44);
    u_host.wr(ASF_OFS_IRQ_CTL, 8'h10);
    pin(1'b0, 1'b1, "empty irq");
    u_host.wr(ASF_OFS_QUEUE_CTL, 8'h04);
    pin(1'b0, 1'b0, "empty gated");
    u_host.wr(ASF_OFS_IRQ_CTL, 8'h0b);
    smp(2'h1, 14'h0005);
    pin(1'b1, 1'b1, "new irq");
    pulse(3'h4);
    pin(1'b0, 1'b1, "new ack");
    u_host.wr(ASF_OFS_IRQ_CTL, 8'h07);
    pulse(3'h1);
    pin(1'b1, 1'b1, "wake irq");
    pulse(3'h4);
    u_host.wr(ASF_OFS_IRQ_CTL, 8'h83);
    pulse(3'h2);
    pin(1'b0, 1'b1, "watched off");
    @(posedge ref_clk);
    watched_active_state <= 1'b1;
    pulse(3'h2);
    pin(1'b1, 1'b1, "watched irq");
    chk("hold", {15'h0, activity_unit_hold}, 16'h1);
    pulse(3'h4);
    pulse(3'h2);
    pin(1'b0, 1'b1, "held");
    @(posedge ref_clk);
    activity_unit_reset <= 1'b1;
    @(posedge ref_clk);
    activity_unit_reset <= 1'b0;
    pin(1'b0, 1'b1, "unheld pin");
    chk("hold cleared", {15'h0, activity_unit_hold}, 16'h0);
    u_host.wr(ASF_OFS_QUEUE_CTL, 8'h42);
    u_host.wr(ASF_OFS_IRQ_CTL, 8'h43);
    smp(2'h0, 14'h0);
    pin(1'b0, 1'b1, "below level");
    smp(2'h0, 14'h0);
    pin(1'b1, 1'b1, "level irq");
    stop_test();
  end
endmodule
